// [logic/acf_consts.vh]
// Constants of the ASCII command frame handler: characters, field sizes, command numbers.
// Assumes inclusion by bare name from the handler module; holds definitions only.
// How it works
// - Responses end in CR plus LF, or CR alone, per delimiter setting.
// - Plain framing has no checksum; checksummed framing puts it after data.
// - Checksum is the low byte of the field sum, as two hex chars.
// - Response checksum covers header and data, not the leading ACK or NAK.
// - A response opens with ACK on success, NAK on error.
// - After ACK the header is echoed, then zero to nine data characters for ordinary commands.
// - An error response is NAK, echoed header, checksum, delimiter, no data.
// - NAK for unsupported number, overlapping command, bad parameter, bad checksum.
// - Polling and other special numbers use their own frame layouts; the handler builds only polling and answers the others with NAK.
// - Value polling returns status plus value in continue state, else status only.
// - Load-and-displacement or displacement axis: load, comma, displacement.
// - Any other axis setup sends only the load field after status.
// - Status-only poll reply: ACK, header, three status chars, checksum, delimiter.
// - First status char is command state digit zero to three.
// - Second status char is measurement state digit zero to three.
// - Third status char is continuous judgment digit zero to nine.
// - Load field is a sign, then six characters with decimal point.
// - Displacement field is a sign, then six characters with decimal point.
`ifndef ACF_CONSTS_VH
`define ACF_CONSTS_VH
`define ACF_HASH      8'h23
`define ACF_CR        8'h0d
`define ACF_LF        8'h0a
`define ACF_ACK       8'h06
`define ACF_NAK       8'h15
`define ACF_COMMA     8'h2c
`define ACF_ZERO      8'h30
`define ACF_NINE      8'h39
`define ACF_PLUS      8'h2b
`define ACF_MINUS     8'h2d
`define ACF_HEX_A     8'h37
`define ACF_RX_MAX    4'd14
`define ACF_LEN_HDR   4'd6
`define ACF_LEN_FULL  4'd12
`define ACF_LEN_CHK   4'd2
`define ACF_HDR_LAST  5'd5
`define ACF_PAY_VALUE 5'd10
`define ACF_PAY_BOTH  5'd18
`define ACF_PAY_STAT  5'd3
`define ACF_RESP_MAX  4'd9
`define ACF_CMD_POLL  32'h30303035
`define ACF_CMD_0006  32'h30303036
`define ACF_CMD_0007  32'h30303037
`define ACF_CMD_0008  32'h30303038
`define ACF_CMD_0010  32'h30303130
`define ACF_CMD_0100  32'h30313030
`define ACF_CMD_0101  32'h30313031
`define ACF_CMD_0110  32'h30313130
`define ACF_CMD_0111  32'h30313131
`define ACF_CMD_0112  32'h30313132
`define ACF_MS_CONT   2'h0
`endif

// [logic/acf_frame_handler.v]
// Command frame receiver, command dispatcher and response framer of the serial host link.
// Assumes bytes arrive already deserialised on clk_sys and the transmitter drains with ready.
`include "acf_consts.vh"

module acf_frame_handler (
   input  wire         clk_sys,
   input  wire         srst,
   input  wire         rx_valid,
   input  wire [7:0]   rx_byte,
   input  wire         tx_ready,
   output wire         tx_valid,
   output wire [7:0]   tx_byte,
   input  wire         cfg_checksum_en,
   input  wire         cfg_crlf_en,
   input  wire [1:0]   command_state_code,
   input  wire [1:0]   measurement_state_code,
   input  wire [3:0]   continuous_judgment_code,
   input  wire         y_axis_load_disp,
   input  wire         x_axis_disp,
   input  wire         load_neg,
   input  wire [47:0]  load_chars,
   input  wire         disp_neg,
   input  wire [47:0]  disp_chars,
   output wire         cmd_valid,
   output wire [31:0]  cmd_number,
   output wire [47:0]  cmd_data,
   input  wire         cmd_done,
   input  wire         cmd_error,
   input  wire [3:0]   cmd_resp_len,
   input  wire [71:0]  cmd_resp_data,
   output wire         busy
);

   localparam [1:0] R_HUNT = 2'd0;
   localparam [1:0] R_TAKE = 2'd1;
   localparam [1:0] R_SKIP = 2'd2;

   localparam [1:0] J_IDLE = 2'd0;
   localparam [1:0] J_EXT  = 2'd1;
   localparam [1:0] J_TX   = 2'd2;

   localparam [1:0] K_NAK  = 2'd0;
   localparam [1:0] K_POLL = 2'd1;
   localparam [1:0] K_EXT  = 2'd2;

   localparam [2:0] P_LEAD = 3'd0;
   localparam [2:0] P_HDR  = 3'd1;
   localparam [2:0] P_PAY  = 3'd2;
   localparam [2:0] P_CK1  = 3'd3;
   localparam [2:0] P_CK2  = 3'd4;
   localparam [2:0] P_CR   = 3'd5;
   localparam [2:0] P_LF   = 3'd6;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function [7:0] hex_char;
      input [3:0] nib;
      begin
         if (nib > 4'd9)
            hex_char = {4'h0, nib} + `ACF_HEX_A;
         else
            hex_char = {4'h0, nib} + `ACF_ZERO;
      end
   endfunction

   function [7:0] sign_char;
      input neg;
      begin
         sign_char = neg ? `ACF_MINUS : `ACF_PLUS;
      end
   endfunction

   function special_num;
      input [31:0] n;
      begin
         special_num = (n == `ACF_CMD_0006) || (n == `ACF_CMD_0007) || (n == `ACF_CMD_0008) ||
                       (n == `ACF_CMD_0010) || (n == `ACF_CMD_0100) || (n == `ACF_CMD_0101) ||
                       (n == `ACF_CMD_0110) || (n == `ACF_CMD_0111) || (n == `ACF_CMD_0112);
      end
   endfunction

   function is_digit;
      input [7:0] c;
      begin
         is_digit = (c >= `ACF_ZERO) && (c <= `ACF_NINE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver

   reg [1:0]  rx_st_q;
   reg [3:0]  rx_cnt_q;
   reg [7:0]  rx_buf_q [0:13];
   reg [7:0]  rx_sum_q;
   reg        rx_ovf_q;
   wire       frame_end;
   integer    i;

   assign frame_end = rx_valid && (rx_st_q == R_TAKE) && (rx_byte == `ACF_CR);

   always @(posedge clk_sys) begin
      if (srst) begin
         rx_st_q  <= R_HUNT;
         rx_cnt_q <= 4'd0;
         rx_sum_q <= 8'h00;
         rx_ovf_q <= 1'b0;
         for (i = 0; i < 14; i = i + 1)
            rx_buf_q[i] <= 8'h00;
      end else if (rx_valid) begin
         case (rx_st_q)
            R_HUNT: begin
               if (rx_byte == `ACF_HASH) begin
                  rx_st_q  <= R_TAKE;
                  rx_cnt_q <= 4'd0;
                  rx_sum_q <= 8'h00;
                  rx_ovf_q <= 1'b0;
               end else if (rx_byte != `ACF_CR) begin
                  rx_st_q <= R_SKIP;
               end
            end
            R_SKIP: begin
               if (rx_byte == `ACF_CR)
                  rx_st_q <= R_HUNT;
            end
            R_TAKE: begin
               if (rx_byte == `ACF_CR) begin
                  rx_st_q <= R_HUNT;
               end else if (rx_cnt_q < `ACF_RX_MAX) begin
                  rx_buf_q[rx_cnt_q] <= rx_byte;
                  rx_cnt_q           <= rx_cnt_q + 4'd1;
                  rx_sum_q           <= rx_sum_q + rx_byte;
               end else begin
                  rx_ovf_q <= 1'b1;
               end
            end
            default: rx_st_q <= R_HUNT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame check at the closing CR

   reg  [3:0]  base_len;
   reg  [7:0]  ck_hi;
   reg  [7:0]  ck_lo;
   reg  [7:0]  exp_sum;
   reg         chk_ok;
   reg  [1:0]  kind;
   wire [31:0] rx_num  = {rx_buf_q[2], rx_buf_q[3], rx_buf_q[4], rx_buf_q[5]};
   wire [47:0] rx_hdr  = {rx_buf_q[0], rx_buf_q[1], rx_num};
   wire [47:0] rx_data = {rx_buf_q[6], rx_buf_q[7], rx_buf_q[8], rx_buf_q[9], rx_buf_q[10], rx_buf_q[11]};

   always @* begin
      base_len = cfg_checksum_en ? `ACF_LEN_CHK : 4'd0;
      ck_hi    = rx_buf_q[rx_cnt_q - 4'd2];
      ck_lo    = rx_buf_q[rx_cnt_q - 4'd1];
      exp_sum  = rx_sum_q - ck_hi - ck_lo;
      chk_ok   = !cfg_checksum_en ||
                 ((rx_cnt_q >= `ACF_LEN_CHK) && (ck_hi == hex_char(exp_sum[7:4])) &&
                  (ck_lo == hex_char(exp_sum[3:0])));
      kind     = K_NAK;
      if (rx_ovf_q || !chk_ok)
         kind = K_NAK;
      else if (rx_num == `ACF_CMD_POLL)
         kind = (rx_cnt_q == `ACF_LEN_HDR + base_len) ? K_POLL : K_NAK;
      else if (special_num(rx_num))
         kind = K_NAK;
      else if (is_digit(rx_buf_q[2]) && is_digit(rx_buf_q[3]) && is_digit(rx_buf_q[4]) &&
               is_digit(rx_buf_q[5]) && (rx_cnt_q == `ACF_LEN_FULL + base_len))
         kind = K_EXT;
      else
         kind = K_NAK;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Job control and response content

   reg [1:0]   job_q;
   reg [47:0]  hdr_q;
   reg [143:0] pay_q;
   reg [4:0]   pay_len_q;
   reg         ack_q;
   reg         ovl_q;
   reg [47:0]  ovl_hdr_q;
   reg         cmd_valid_q;
   reg [31:0]  cmd_number_q;
   reg [47:0]  cmd_data_q;
   reg         busy_q;
   wire        tx_last;
   wire [23:0] stat3 = {6'h0c, command_state_code, 6'h0c, measurement_state_code,
                        4'h3, continuous_judgment_code};
   wire [55:0] load_f = {sign_char(load_neg), load_chars};
   wire [55:0] disp_f = {sign_char(disp_neg), disp_chars};

   always @(posedge clk_sys) begin
      if (srst) begin
         job_q        <= J_IDLE;
         hdr_q        <= 48'h0;
         pay_q        <= 144'h0;
         pay_len_q    <= 5'd0;
         ack_q        <= 1'b0;
         ovl_q        <= 1'b0;
         ovl_hdr_q    <= 48'h0;
         cmd_valid_q  <= 1'b0;
         cmd_number_q <= 32'h0;
         cmd_data_q   <= 48'h0;
         busy_q       <= 1'b0;
      end else begin
         cmd_valid_q <= 1'b0;
         if (frame_end && (job_q != J_IDLE || ovl_q)) begin
            if (!ovl_q) begin
               ovl_q     <= 1'b1;
               ovl_hdr_q <= rx_hdr;
            end
         end
         case (job_q)
            J_IDLE: begin
               if (frame_end && !ovl_q) begin
                  hdr_q     <= rx_hdr;
                  pay_len_q <= 5'd0;
                  ack_q     <= (kind != K_NAK);
                  if (kind == K_POLL) begin
                     job_q <= J_TX;
                     if (measurement_state_code != `ACF_MS_CONT) begin
                        pay_q     <= {stat3, 120'h0};
                        pay_len_q <= `ACF_PAY_STAT;
                     end else if (y_axis_load_disp || x_axis_disp) begin
                        pay_q     <= {stat3, load_f, `ACF_COMMA, disp_f};
                        pay_len_q <= `ACF_PAY_BOTH;
                     end else begin
                        pay_q     <= {stat3, load_f, 64'h0};
                        pay_len_q <= `ACF_PAY_VALUE;
                     end
                  end else if (kind == K_EXT) begin
                     job_q        <= J_EXT;
                     cmd_valid_q  <= 1'b1;
                     cmd_number_q <= rx_num;
                     cmd_data_q   <= rx_data;
                  end else begin
                     job_q <= J_TX;
                  end
               end
            end
            J_EXT: begin
               if (cmd_done) begin
                  job_q <= J_TX;
                  ack_q <= !cmd_error;
                  pay_q <= {cmd_resp_data, 72'h0};
                  if (cmd_error)
                     pay_len_q <= 5'd0;
                  else if (cmd_resp_len > `ACF_RESP_MAX)
                     pay_len_q <= {1'b0, `ACF_RESP_MAX};
                  else
                     pay_len_q <= {1'b0, cmd_resp_len};
               end
            end
            J_TX: begin
               if (tx_last) begin
                  if (ovl_q || frame_end) begin
                     hdr_q     <= ovl_q ? ovl_hdr_q : rx_hdr;
                     ack_q     <= 1'b0;
                     pay_len_q <= 5'd0;
                     ovl_q     <= 1'b0;
                  end else begin
                     job_q <= J_IDLE;
                  end
               end
            end
            default: job_q <= J_IDLE;
         endcase
         busy_q <= (job_q != J_IDLE) || ovl_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response framer

   reg  [2:0]  ph_q;
   reg  [4:0]  idx_q;
   reg  [7:0]  tsum_q;
   reg         tx_valid_q;
   reg  [7:0]  tx_byte_q;
   reg  [7:0]  nxt_byte;
   reg  [2:0]  nxt_ph;
   reg  [4:0]  nxt_idx;
   reg         nxt_done;
   reg  [2:0]  after_data;
   wire        tx_go = (job_q == J_TX) && (!tx_valid_q || tx_ready);

   assign tx_last = tx_go && nxt_done;

   always @* begin
      after_data = cfg_checksum_en ? P_CK1 : P_CR;
      nxt_ph     = ph_q;
      nxt_idx    = idx_q + 5'd1;
      nxt_done   = 1'b0;
      nxt_byte   = `ACF_CR;
      case (ph_q)
         P_LEAD: begin
            nxt_byte = ack_q ? `ACF_ACK : `ACF_NAK;
            nxt_ph   = P_HDR;
            nxt_idx  = 5'd0;
         end
         P_HDR: begin
            nxt_byte = hdr_q[47 - 8 * idx_q -: 8];
            if (idx_q == `ACF_HDR_LAST) begin
               nxt_ph  = (pay_len_q != 5'd0) ? P_PAY : after_data;
               nxt_idx = 5'd0;
            end
         end
         P_PAY: begin
            nxt_byte = pay_q[143 - 8 * idx_q -: 8];
            if (idx_q == pay_len_q - 5'd1) begin
               nxt_ph  = after_data;
               nxt_idx = 5'd0;
            end
         end
         P_CK1: begin
            nxt_byte = hex_char(tsum_q[7:4]);
            nxt_ph   = P_CK2;
         end
         P_CK2: begin
            nxt_byte = hex_char(tsum_q[3:0]);
            nxt_ph   = P_CR;
         end
         P_CR: begin
            nxt_byte = `ACF_CR;
            nxt_ph   = P_LF;
            nxt_done = !cfg_crlf_en;
         end
         default: begin
            nxt_byte = `ACF_LF;
            nxt_done = 1'b1;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         ph_q       <= P_LEAD;
         idx_q      <= 5'd0;
         tsum_q     <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h00;
      end else if (tx_go) begin
         tx_valid_q <= 1'b1;
         tx_byte_q  <= nxt_byte;
         if (nxt_done) begin
            ph_q   <= P_LEAD;
            idx_q  <= 5'd0;
            tsum_q <= 8'h00;
         end else begin
            ph_q  <= nxt_ph;
            idx_q <= nxt_idx;
            if (ph_q == P_HDR || ph_q == P_PAY)
               tsum_q <= tsum_q + nxt_byte;
         end
      end else if (tx_ready) begin
         tx_valid_q <= 1'b0;
      end
   end

   assign tx_valid   = tx_valid_q;
   assign tx_byte    = tx_byte_q;
   assign cmd_valid  = cmd_valid_q;
   assign cmd_number = cmd_number_q;
   assign cmd_data   = cmd_data_q;
   assign busy       = busy_q;

endmodule

// [test/acf_frame_monitor.sv]
// Port checker of the frame handler: reply endings, lead bytes, handshake and command strobe.
// Assumes bind to acf_frame_handler; all signals on clk_sys, srst synchronous active high.
module acf_frame_monitor (
   input wire        clk_sys,
   input wire        srst,
   input wire        rx_valid,
   input wire [7:0]  rx_byte,
   input wire        tx_ready,
   input wire        tx_valid,
   input wire [7:0]  tx_byte,
   input wire        cfg_crlf_en,
   input wire        cmd_valid,
   input wire [31:0] cmd_number,
   input wire        cmd_done,
   input wire        cmd_error,
   input wire        busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////////
   logic cr_seen_q;
   logic done_q;
   always @(posedge clk_sys) begin
      cr_seen_q <= rx_valid && rx_byte == 8'h0d;
      done_q <= cmd_done;
   end
   sequence s_cr_taken;
      tx_valid && tx_ready && tx_byte == 8'h0d;
   endsequence
   sequence s_waiting_done;
      cmd_done && busy && !tx_valid;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_lf_follows: assert property (s_cr_taken ##0 cfg_crlf_en |=> tx_valid && tx_byte == 8'h0a)
      else $error("LF missing after CR");
   chk_cr_alone: assert property (s_cr_taken ##0 !cfg_crlf_en |=> !(tx_valid && tx_byte == 8'h0a))
      else $error("LF sent in CR-only mode");
   chk_lead_byte: assert property ($rose(tx_valid) |-> tx_byte == 8'h06 || tx_byte == 8'h15)
      else $error("Reply starts without ACK or NAK");
   chk_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("Reply byte changed before taken");
   chk_done_ack: assert property (s_waiting_done ##0 !cmd_error |=> ##1 tx_valid && tx_byte == 8'h06)
      else $error("No ACK after command done");
   chk_err_nak: assert property (s_waiting_done ##0 cmd_error |=> ##1 tx_valid && tx_byte == 8'h15)
      else $error("No NAK after command error");
   chk_cmd_at_cr: assert property (cmd_valid |-> cr_seen_q)
      else $error("Command strobe without closing CR");
   chk_poll_start: assert property ($rose(tx_valid) && tx_byte == 8'h06 && !$past(done_q) |-> $past(cr_seen_q))
      else $error("Poll reply not started after CR");
   chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("Command strobe longer than one cycle");
   chk_num_hold: assert property ($changed(cmd_number) |-> cmd_valid)
      else $error("Command number changed without strobe");
   chk_busy_on: assert property (cmd_valid |=> busy)
      else $error("Not busy while command runs");
endmodule

bind acf_frame_handler acf_frame_monitor u_mon (.clk_sys, .srst, .rx_valid, .rx_byte, .tx_ready, .tx_valid,
   .tx_byte, .cfg_crlf_en, .cmd_valid, .cmd_number, .cmd_done, .cmd_error, .busy);

// [test/acf_host_model.sv]
// Host side of the serial link: sends queued command bytes one a cycle, drains reply bytes.
// Assumes the bench queues whole frames with send and reads replies from got.
module acf_host_model (
   input  wire        clk_sys,
   output logic       rx_valid,
   output logic [7:0] rx_byte,
   output logic       tx_ready,
   input  wire        tx_valid,
   input  wire [7:0]  tx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] out_q[$];
   logic [7:0] got[$];
   bit         slow = 1'b0;
   int         ph = 0;
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
   end
   // Frames arrive whole from the bench, opening hash and closing CR included
   task send(input string s);
      for (int i = 0; i < s.len(); i++)
         out_q.push_back(s[i]);
   endtask
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_byte);
      #1;
      ph = ph + 1;
      tx_ready = !slow || ph[0];
      if (out_q.size() > 0) begin
         rx_valid = 1'b1;
         rx_byte = out_q.pop_front();
      end else begin
         rx_valid = 1'b0;
         // Idle line inverts the held byte on every idle cycle
         rx_byte = ~rx_byte;
      end
   end
endmodule

// [test/acf_frame_handler_bench.sv]
// Self-checking bench of the frame handler: polls, ordinary commands, refusals, overlap.
// Assumes the host model drives the receive side; the bench plays the command executor.
module acf_frame_handler_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        cfg_checksum_en = 1'b0;
   logic        cfg_crlf_en = 1'b0;
   logic [1:0]  command_state_code = 2'h0;
   logic [1:0]  measurement_state_code = 2'h1;
   logic [3:0]  continuous_judgment_code = 4'h0;
   logic        y_axis_load_disp = 1'b0;
   logic        x_axis_disp = 1'b0;
   logic        load_neg = 1'b0;
   logic [47:0] load_chars = "012.34";
   logic        disp_neg = 1'b1;
   logic [47:0] disp_chars = "5.0071";
   logic        cmd_done = 1'b0;
   logic        cmd_error = 1'b0;
   logic [3:0]  cmd_resp_len = 4'h0;
   logic [71:0] cmd_resp_data = 72'h0;
   wire         rx_valid, tx_ready, tx_valid, cmd_valid, busy;
   wire [7:0]   rx_byte, tx_byte;
   wire [31:0]  cmd_number;
   wire [47:0]  cmd_data;
   int          miscompares = 0;
   int          n_checks = 0;
   string       un[9] = '{"0006", "0007", "0008", "0010", "0100", "0101", "0110", "0111", "0112"};

   always #4 clk_sys = ~clk_sys;

   acf_frame_handler u_dut (.clk_sys, .srst, .rx_valid, .rx_byte, .tx_ready, .tx_valid, .tx_byte,
      .cfg_checksum_en, .cfg_crlf_en, .command_state_code, .measurement_state_code, .continuous_judgment_code,
      .y_axis_load_disp, .x_axis_disp, .load_neg, .load_chars, .disp_neg, .disp_chars, .cmd_valid, .cmd_number,
      .cmd_data, .cmd_done, .cmd_error, .cmd_resp_len, .cmd_resp_data, .busy);
   acf_host_model u_host (.clk_sys, .rx_valid, .rx_byte, .tx_ready, .tx_valid, .tx_byte);
   ////////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task check(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tick;
      @(posedge clk_sys);
      #1;
   endtask
   task end_test(input string n);
      $display("test %s done", n);
   endtask
   function string hx(input logic [3:0] n);
      hx = string'(n < 10 ? 8'h30 + n : 8'h37 + n);
   endfunction
   function string dg(input int n);
      dg = string'(8'h30 + n[7:0]);
   endfunction
   function string cs(input string s);
      logic [7:0] t;
      t = 8'h00;
      for (int i = 0; i < s.len(); i++)
         t += s[i];
      cs = {hx(t[7:4]), hx(t[3:0])};
   endfunction
   function string frm(input string b);
      frm = {"#", b, cfg_checksum_en ? cs(b) : "", "\r"};
   endfunction
   function string rsp(input logic [7:0] ld, input string b);
      rsp = {string'(ld), b, cfg_checksum_en ? cs(b) : "", cfg_crlf_en ? "\r\n" : string'("\r")};
   endfunction
   task expect_resp(input string e);
      int k;
      k = 0;
      while (u_host.got.size() < e.len() && k < 600) begin
         tick;
         k++;
      end
      if (u_host.got.size() < e.len()) begin
         miscompares++;
         stop_test;
      end
      repeat (6) tick;
      check(u_host.got.size(), e.len());
      for (int i = 0; i < e.len() && i < u_host.got.size(); i++)
         check(u_host.got[i], e[i]);
      u_host.got.delete();
   endtask
   task wait_cmd;
      int k;
      k = 0;
      tick;
      while (cmd_valid !== 1'b1 && k < 300) begin
         tick;
         k++;
      end
      if (cmd_valid !== 1'b1) begin
         miscompares++;
         stop_test;
      end
   endtask
   task finish_cmd(input logic err, input logic [3:0] n, input logic [71:0] d);
      tick;
      cmd_error = err;
      cmd_resp_len = n;
      cmd_resp_data = d;
      cmd_done = 1'b1;
      tick;
      cmd_done = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) tick;
      srst = 1'b0;
      tick;
      for (int j = 0; j < 10; j++) begin
         continuous_judgment_code = j[3:0];
         command_state_code = j[1:0];
         measurement_state_code = 2'(1 + j % 3);
         u_host.send(frm("000005"));
         expect_resp(rsp(8'h06, {"000005", dg(j % 4), dg(1 + j % 3), dg(j)}));
      end
      end_test("status_poll");
      cfg_checksum_en = 1'b1;
      cfg_crlf_en = 1'b1;
      u_host.slow = 1'b1;
      measurement_state_code = 2'h0;
      for (int a = 0; a < 4; a++) begin
         y_axis_load_disp = a[0];
         x_axis_disp = a[1];
         load_neg = a[0];
         u_host.send(frm("000005"));
         expect_resp(rsp(8'h06, {"000005109", a[0] ? "-" : "+", "012.34",
                                 a > 0 ? ",-5.0071" : string'("")}));
      end
      end_test("value_poll");
      u_host.send(frm("007000000006"));
      wait_cmd;
      check(cmd_number, "7000");
      check(cmd_data, "000006");
      finish_cmd(1'b0, 4'h9, "123456789");
      expect_resp(rsp(8'h06, "007000123456789"));
      u_host.send(frm("007000000006"));
      wait_cmd;
      finish_cmd(1'b1, 4'h0, 72'h0);
      expect_resp(rsp(8'h15, "007000"));
      u_host.send("#00700000000600\r");
      expect_resp(rsp(8'h15, "007000"));
      u_host.send("#0070000000064d\r");
      expect_resp(rsp(8'h15, "007000"));
      u_host.send(frm("0070000000060"));
      expect_resp(rsp(8'h15, "007000"));
      foreach (un[i]) begin
         u_host.send(frm({"00", un[i]}));
         expect_resp(rsp(8'h15, {"00", un[i]}));
      end
      end_test("commands");
      u_host.send("x#00\r");
      repeat (40) tick;
      check(u_host.got.size(), 0);
      u_host.send(frm("007000000006"));
      wait_cmd;
      u_host.send(frm("000005"));
      repeat (30) tick;
      check(busy, 1'b1);
      finish_cmd(1'b0, 4'h0, 72'h0);
      expect_resp({rsp(8'h06, "007000"), rsp(8'h15, "000005")});
      check(busy, 1'b0);
      end_test("discard_overlap");
      stop_test;
   end
endmodule
